// File: pkg/csram_pkg.sv
// Shared constants for the clocked static memory link
package csram_pkg;
  localparam int unsigned CSR_WORDS      = 1024;
  localparam int unsigned CSR_AW         = 10;
  localparam int unsigned CSR_DW         = 4;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned ACCESS_NS      = 200;
  localparam int unsigned PRESET_NS      = 100;
  localparam int unsigned ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRESET_CYC     = (PRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  CNT_RST        = 8'h00;
  localparam logic [3:0]  DATA_RST       = 4'h0;
endpackage

// File: pkg/csram_if.sv
// Pin-level link between memory and controller
`timescale 1ns/1ns
interface csram_if;
  import csram_pkg::*;
  logic              cyc_clk;
  logic [CSR_AW-1:0] addr;
  logic              sel_n;
  logic              wr_n;
  logic [CSR_DW-1:0] dq_ctl_o;
  logic              dq_ctl_oe;
  logic [CSR_DW-1:0] dq_mem_o;
  logic              dq_mem_oe;
  logic              status;
  logic [CSR_DW-1:0] dq;
  assign dq = dq_mem_oe ? dq_mem_o : (dq_ctl_oe ? dq_ctl_o : '0);
  modport mem (input cyc_clk, input addr, input sel_n, input wr_n, input dq,
               output dq_mem_o, output dq_mem_oe, output status);
  modport ctl (output cyc_clk, output addr, output sel_n, output wr_n,
               output dq_ctl_o, output dq_ctl_oe, input dq, input status);
endinterface

// File: design/csram_mem.sv
// Clocked static memory end, 1024 words of 4 bits
// What this block does
// - Store 1024 words of four bits
// - Cycle starts on cycle clock rising edge
// - Clock low runs the internal preset
// - Latch address and select at cycle start
// - Read data held until next cycle
// - Controller keeps write request high reading
// - Write request low stores pin data when selected
// - Shared pins driven only by data owner
// - Status marks data valid, preset done
// - Controller may self-time from status
// - Halted cycle clock keeps state intact
`timescale 1ns/1ns
module csram_mem
  import csram_pkg::*;
#(
  parameter int unsigned ACC_CYC = ACCESS_CYC,
  parameter int unsigned PRE_CYC = PRESET_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  csram_if.mem      pins
);
  typedef enum logic [1:0] {CSRM_READY, CSRM_ACTIVE, CSRM_PRESET} csram_st_t;

  csram_st_t         st_q;
  csram_st_t         st_d;
  logic [7:0]        cnt_q;
  logic [7:0]        cnt_d;
  logic              ce_q;
  logic [CSR_AW-1:0] adr_q;
  logic              sel_q;
  logic              wrote_q;
  logic [CSR_DW-1:0] dout_q;
  logic              oe_q;
  logic              stat_q;
  logic [CSR_DW-1:0] mem_q [CSR_WORDS];
  logic              rise;
  logic              fall;
  logic              in_ready;
  logic              in_active;
  logic              in_preset;
  logic              start;
  logic              acc_done;
  logic              pre_done;
  logic              wr_now;
  logic              valid_now;
  logic              end_cyc;
  logic              ready_now;
  logic              rd_ok;
  logic [CSR_DW-1:0] rd_word;
  logic              cnt_clr;
  logic              cnt_inc;
  logic              stat_clr;
  logic              stat_set;

  // Edge detect on the cycle clock
  assign rise      = pins.cyc_clk & ~ce_q;
  assign fall      = ~pins.cyc_clk & ce_q;
  // State decode
  assign in_ready  = (st_q == CSRM_READY);
  assign in_active = (st_q == CSRM_ACTIVE);
  assign in_preset = (st_q == CSRM_PRESET);
  assign start     = rise && in_ready;
  // Interval counter end points
  assign acc_done  = (cnt_q == 8'(ACC_CYC));
  assign pre_done  = (cnt_q == 8'(PRE_CYC));
  assign wr_now    = in_active && sel_q && pins.cyc_clk && !pins.wr_n;
  assign valid_now = in_active && acc_done && !stat_q;
  assign end_cyc   = in_active && fall;
  assign ready_now = in_preset && pre_done;
  assign rd_ok     = sel_q && pins.wr_n && !wrote_q;
  assign rd_word   = mem_q[adr_q];
  // Counter control
  assign cnt_clr   = start || end_cyc;
  assign cnt_inc   = (in_active && !acc_done) || (in_preset && !pre_done);
  assign cnt_d     = cnt_clr ? CNT_RST : (cnt_inc ? cnt_q + 8'h01 : cnt_q);
  // Status control
  assign stat_clr  = start || end_cyc;
  assign stat_set  = valid_now || ready_now;

  // Cycle sequencing
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      CSRM_READY: begin
        if (start) begin
          st_d = CSRM_ACTIVE;
        end
      end
      CSRM_ACTIVE: begin
        if (fall) begin
          st_d = CSRM_PRESET;
        end
      end
      CSRM_PRESET: begin
        if (pre_done) begin
          st_d = CSRM_READY;
        end
      end
      default: st_d = CSRM_READY;
    endcase
  end

  // State and edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= CSRM_READY;
      ce_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ce_q <= pins.cyc_clk;
    end
  end

  // Interval counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adr_q <= '0;
    end else if (start) begin
      adr_q <= pins.addr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
    end else if (start) begin
      sel_q <= ~pins.sel_n;
    end
  end

  // Write seen in this cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrote_q <= 1'b0;
    end else if (start) begin
      wrote_q <= 1'b0;
    end else if (wr_now) begin
      wrote_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= 1'b1;
    end else if (stat_clr) begin
      stat_q <= 1'b0;
    end else if (stat_set) begin
      stat_q <= 1'b1;
    end
  end

  // Output enable held to next start, cleared early by a write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else if (start) begin
      oe_q <= 1'b0;
    end else if (valid_now) begin
      oe_q <= rd_ok;
    end else if (wr_now) begin
      oe_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout_q <= DATA_RST;
    end else if (valid_now) begin
      dout_q <= rd_word;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_now) begin
      mem_q[adr_q] <= pins.dq;
    end
  end

  // Drive pins only for read data
  assign pins.dq_mem_o  = dout_q;
  assign pins.dq_mem_oe = oe_q;
  assign pins.status    = stat_q;
endmodule

// File: design/csram_ctl.sv
// Controller end, self-timed from the memory status
`timescale 1ns/1ns
module csram_ctl
  import csram_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              req,
  input  wire logic              req_wr,
  input  wire logic [CSR_AW-1:0] req_addr,
  input  wire logic [CSR_DW-1:0] req_wdata,
  input  wire logic              req_sel,
  output logic                   busy,
  output logic                   done,
  output logic [CSR_DW-1:0]      rdata,
  csram_if.ctl                   pins
);
  typedef enum logic [2:0] {CSRC_IDLE, CSRC_HIGH, CSRC_WAIT, CSRC_LOW, CSRC_PRE} csram_cst_t;

  csram_cst_t        st_q;
  logic              ce_q;
  logic [CSR_AW-1:0] adr_q;
  logic              wrn_q;
  logic              wr_q;
  logic              seln_q;
  logic [CSR_DW-1:0] wd_q;
  logic              oe_q;
  logic              busy_q;
  logic              done_q;
  logic [CSR_DW-1:0] rd_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q   <= CSRC_IDLE;
      ce_q   <= 1'b0;
      adr_q  <= '0;
      wrn_q  <= 1'b1;
      seln_q <= 1'b1;
      wr_q   <= 1'b0;
      wd_q   <= DATA_RST;
      oe_q   <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rd_q   <= DATA_RST;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        CSRC_IDLE: begin
          if (req && pins.status) begin
            adr_q  <= req_addr;
            wr_q   <= req_wr;
            seln_q <= ~req_sel;
            wd_q   <= req_wdata;
            ce_q   <= 1'b1;
            busy_q <= 1'b1;
            st_q   <= CSRC_HIGH;
          end
        end
        CSRC_HIGH: begin
          wrn_q <= ~wr_q;
          oe_q  <= wr_q;
          st_q  <= CSRC_WAIT;
        end
        CSRC_WAIT: begin
          if (pins.status) begin
            if (!wr_q && !seln_q) begin
              rd_q <= pins.dq;
            end
            wrn_q <= 1'b1;
            oe_q  <= 1'b0;
            st_q  <= CSRC_LOW;
          end
        end
        CSRC_LOW: begin
          ce_q <= 1'b0;
          st_q <= CSRC_PRE;
        end
        CSRC_PRE: begin
          if (!pins.status) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q   <= CSRC_IDLE;
          end
        end
        default: st_q <= CSRC_IDLE;
      endcase
    end
  end

  assign pins.cyc_clk   = ce_q;
  assign pins.addr      = adr_q;
  assign pins.sel_n     = seln_q;
  assign pins.wr_n      = wrn_q;
  assign pins.dq_ctl_o  = wd_q;
  assign pins.dq_ctl_oe = oe_q;
  assign busy           = busy_q;
  assign done           = done_q;
  assign rdata          = rd_q;
endmodule

// File: sim/csram_checker.sv
// Pin-level checker for the clocked memory link
`timescale 1ns/1ns
module csram_checker
  import csram_pkg::*;
#(
  parameter int unsigned ACC_CYC = ACCESS_CYC,
  parameter int unsigned PRE_CYC = PRESET_CYC
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              cyc_clk,
  input wire logic              wr_n,
  input wire logic              dq_ctl_oe,
  input wire logic              dq_mem_oe,
  input wire logic [CSR_DW-1:0] dq_mem_o,
  input wire logic              status,
  input wire logic              sel_n
);
  localparam int AMAX = ACC_CYC + 3;
  localparam int PMAX = PRE_CYC + 3;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_start_status: assert property ($rose(cyc_clk) && status |=> !status) else $error("no busy at start");
  chk_access_bound: assert property ($rose(cyc_clk) && status |=> !status ##[1:AMAX] status)
    else $error("access too long");
  chk_preset_bound: assert property ($fell(cyc_clk) |-> ##[1:2] !status ##[1:PMAX] status)
    else $error("preset wrong");
  chk_raise_ready: assert property ($rose(cyc_clk) |-> $past(status)) else $error("raised while busy");
  chk_fall_valid: assert property ($fell(cyc_clk) |-> $past(status)) else $error("lowered early");
  chk_bus_owner: assert property (dq_mem_oe |-> !dq_ctl_oe) else $error("bus contention");
  chk_write_high: assert property ($fell(wr_n) |-> cyc_clk) else $error("write outside cycle");
  chk_data_held: assert property (dq_mem_oe && !$rose(cyc_clk) |=> $stable(dq_mem_o))
    else $error("read data moved");
  chk_oe_valid: assert property ($rose(dq_mem_oe) |-> $rose(status) && cyc_clk && wr_n)
    else $error("oe without valid read");
  cov_read: cover property ($rose(dq_mem_oe));
  cov_write: cover property ($fell(wr_n));
  chk_sel_drive: assert property ($rose(dq_mem_oe) |-> !sel_n) else $error("drive when unselected");
  cov_preset: cover property ($fell(cyc_clk) ##[1:PMAX] status);
  cov_unsel: cover property ($rose(cyc_clk) && sel_n);
endmodule

// File: sim/csram_test.sv
// Self-checking bench for the clocked memory link
`timescale 1ns/1ns
module csram_test;
  import csram_pkg::*;
  logic              clk       = 1'b0;
  logic              rst_n     = 1'b0;
  logic              req       = 1'b0;
  logic              req_wr    = 1'b0;
  logic [CSR_AW-1:0] req_addr  = '0;
  logic [CSR_DW-1:0] req_wdata = '0;
  logic              req_sel   = 1'b0;
  logic              busy;
  logic              done;
  logic [CSR_DW-1:0] rdata;
  logic [CSR_DW-1:0] e;
  int                n_mismatch  = 0;
  int                checks_done = 0;
  logic [CSR_AW-1:0] at [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
  logic [CSR_DW-1:0] dt [4] = '{4'hA, 4'h5, 4'hF, 4'h0};
  csram_if u_if ();
  csram_mem #(.ACC_CYC(2), .PRE_CYC(2)) u_csram_mem (.clk(clk), .rst_n(rst_n), .pins(u_if.mem));
  csram_ctl u_csram_ctl (.clk(clk), .rst_n(rst_n), .req(req), .req_wr(req_wr), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_sel(req_sel), .busy(busy), .done(done), .rdata(rdata), .pins(u_if.ctl));
  csram_checker #(.ACC_CYC(2), .PRE_CYC(2)) u_csram_checker (.clk(clk), .rst_n(rst_n),
    .cyc_clk(u_if.cyc_clk), .wr_n(u_if.wr_n), .dq_ctl_oe(u_if.dq_ctl_oe), .dq_mem_oe(u_if.dq_mem_oe),
    .dq_mem_o(u_if.dq_mem_o), .status(u_if.status), .sel_n(u_if.sel_n));
  initial forever #4 clk = ~clk;
  task automatic test_done;
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [CSR_DW-1:0] seen, input logic [CSR_DW-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One full access, request dropped once taken
  task automatic xfer(input logic w, input logic s, input logic [CSR_AW-1:0] a, input logic [CSR_DW-1:0] d);
    int n;
    n = 0;
    req <= 1'b1;
    req_wr <= w;
    req_sel <= s;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(posedge clk);
      n++;
      if (busy === 1'b1)
        req <= 1'b0;
    end while (done !== 1'b1 && n < 200);
    if (done !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 1'b1, at[i], dt[i]);
      check("oe after write", {3'h0, u_if.dq_mem_oe}, 4'h0);
    end
    repeat (300) @(posedge clk);
    xfer(1'b1, 1'b1, 10'h3FF, 4'h3);
    for (int i = 3; i >= 0; i--) begin
      e = (i == 1) ? 4'h3 : dt[i];
      xfer(1'b0, 1'b1, at[i], 4'h0);
      check("rdata", rdata, e);
      repeat (3) @(posedge clk);
      check("pin data", u_if.dq, e);
      check("read oe", {3'h0, u_if.dq_mem_oe}, 4'h1);
    end
    xfer(1'b1, 1'b0, at[2], 4'h1);
    xfer(1'b0, 1'b0, at[2], 4'h0);
    check("unsel rdata", rdata, 4'hA);
    check("unsel oe", {3'h0, u_if.dq_mem_oe}, 4'h0);
    xfer(1'b0, 1'b1, at[2], 4'h0);
    check("kept word", rdata, 4'hF);
    check("busy idle", {3'h0, busy}, 4'h0);
    test_done();
  end
endmodule
